// [dps_pkg.sv]
// Purpose: Shared types and constants for the debug port protocol selector
// Assumes: Debug clock and data/mode pin are sampled by the fast system clock
// Notes: Pattern values are as sent most significant bit first
`default_nettype none
package dps_pkg;

    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } dps_tap_t;

    typedef enum logic [1:0] {
        MODE_JTAG, MODE_TWO_WIRE, MODE_DORMANT
    } dps_mode_t;

    // Select patterns, first bit on the wire is bit 15
    localparam logic [15:0] SEL_TO_JTAG = 16'h3CE7;
    localparam logic [15:0] SEL_TO_TWO_WIRE = 16'h79E7;
    localparam logic [4:0] PAT_LAST = 5'h0F;
    localparam logic [4:0] PAT_DONE = 5'h10;

    // Consecutive high data/mode bits that define each reset condition
    localparam logic [5:0] LINE_RESET_HIGHS = 6'h32;
    localparam logic [5:0] TAP_RESET_HIGHS = 6'h05;

    // Zero-length scan counter limits
    localparam logic [2:0] ZS_MAX = 3'h7;
    localparam logic [2:0] ZS_DORMANT = 3'h6;
    localparam logic [2:0] ZS_ZERO = 3'h0;
    localparam logic [2:0] ZS_ONE = 3'h1;

endpackage
`default_nettype wire

// [dps_zs_if.sv]
// Purpose: Carries TAP transitions to the zero-length scan detector
// Assumes: One step pulse per TAP transition, in the system clock domain
// Notes: enter is combinational from the detector state
`timescale 1ns/1ps
`default_nettype none
interface dps_zs_if;
    import dps_pkg::*;
    logic step;
    dps_tap_t tap_next;
    logic enter;
    logic [2:0] count;
    logic lock;
    modport host (output step, output tap_next, input enter, input count, input lock);
    modport det (input step, input tap_next, output enter, output count, output lock);
endinterface
`default_nettype wire

// [dps_zscan.sv]
// Purpose: Zero-length data-register scan counter and dormant entry detector
// Assumes: step marks each TAP transition, tap_next is the state being entered
// Notes: State updates only on step, so a stopped debug clock freezes it
`timescale 1ns/1ps
`default_nettype none
module dps_zscan (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    dps_zs_if.det zi
);
    import dps_pkg::*;

    typedef struct packed {
        logic shift_seen_flag;
        logic [2:0] zero_scan_counter;
        logic zero_scan_lock;
    } dps_zs_st_t;

    localparam dps_zs_st_t ZS_RST = '{shift_seen_flag: 1'b0, zero_scan_counter: ZS_ZERO,
                                      zero_scan_lock: 1'b0};

    dps_zs_st_t st;
    dps_zs_st_t next_st;
    logic clr;

    assign clr = zi.tap_next == TAP_SEL_IR || zi.tap_next == TAP_TLR;

    always_comb begin
        next_st = st;
        if (zi.step) begin
            case (zi.tap_next)
                TAP_CAP_DR: begin
                    next_st.shift_seen_flag = 1'b0;
                end
                TAP_SH_DR: begin
                    next_st.shift_seen_flag = 1'b1;
                    if (st.zero_scan_counter != ZS_ZERO) begin
                        next_st.zero_scan_lock = 1'b1;
                    end
                end
                TAP_UPD_DR: begin
                    if (!st.zero_scan_lock && !st.shift_seen_flag &&
                        st.zero_scan_counter < ZS_MAX) begin
                        next_st.zero_scan_counter = st.zero_scan_counter + ZS_ONE;
                    end
                end
                TAP_SEL_IR, TAP_TLR: begin
                    next_st.zero_scan_counter = ZS_ZERO;
                    next_st.zero_scan_lock = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // Fresh count after dormant entry, so waking at idle cannot enter again
        if (zi.enter) begin
            next_st = ZS_RST;
        end
    end

    assign zi.enter = zi.step && zi.tap_next == TAP_RTI && st.zero_scan_lock &&
                      st.zero_scan_counter == ZS_DORMANT;
    assign zi.count = st.zero_scan_counter;
    assign zi.lock = st.zero_scan_lock;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= ZS_RST;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    chk_zs_flag_capture: assert property (i_ce && zi.step && zi.tap_next == TAP_CAP_DR
        |=> !st.shift_seen_flag) else $error("scan flag not cleared at capture");
    chk_zs_clear_unlock: assert property (i_ce && zi.step && clr
        |=> st.zero_scan_counter == ZS_ZERO && !st.zero_scan_lock)
        else $error("zero scan counter not cleared");
    chk_zs_saturate: assert property (st.zero_scan_counter == ZS_MAX && !(zi.step && clr)
        |=> st.zero_scan_counter == ZS_MAX) else $error("zero scan counter wrapped");
    chk_zs_lock_hold: assert property (st.zero_scan_lock && !(zi.step && clr) && !zi.enter
        |=> st.zero_scan_lock && $stable(st.zero_scan_counter))
        else $error("locked count moved");
    chk_zs_enter_six: assert property (zi.enter
        |-> zi.lock && zi.count == ZS_DORMANT && zi.tap_next == TAP_RTI)
        else $error("dormant entry without locked six");
    chk_zs_enter_fresh: assert property (i_ce && zi.enter
        |=> st.zero_scan_counter == ZS_ZERO && !st.zero_scan_lock)
        else $error("count not cleared after dormant entry");

    cov_zs_locked_six: cover property (st.zero_scan_lock && st.zero_scan_counter == ZS_DORMANT);

endmodule // dps_zscan
`default_nettype wire

// [dps_top.sv]
// Purpose: Protocol selection watcher for a dual protocol debug port
// Assumes: Debug clock at most one tenth of i_mclk; alert and activation
//          matches come from same-clock logic as one-cycle pulses
// Notes: Pins pass three flops; a change counts once stages two and three agree
//
// Summary of operation
// - Two-wire to JTAG pattern only from line reset
// - Two-wire to JTAG pattern is 0x3CE7
// - Dormant ignores everything except selection alert; TAP reset pin still resets the TAP
// - Alert then activation code leaves dormant
// - Dormant operation always implemented here
// - Dormant entry from JTAG or two-wire
// - JTAG activation keeps TAP state from entry
// - Two-wire activation leaves reset pending
// - Two-wire only build starts dormant
// - Shift flag cleared at capture, set at shift
// - Counter cleared on select-IR, TLR, reset
// - Zero scan increments, saturating at seven
// - Shift with nonzero count locks counter
// - Idle with locked six enters dormant
// - TLR abandon rearms two-wire pattern detection
// - After a match, ignore patterns until reset
// - JTAG to two-wire pattern is 0x79E7
// - Powerup selects JTAG with TAP in TLR when JTAG_PRESENT
`timescale 1ns/1ps
`default_nettype none
module dps_top #(
    parameter bit JTAG_PRESENT = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_debug_clock_pin,
    input wire logic i_data_mode_pin,
    input wire logic i_tap_reset_n,
    input wire logic i_alert_seen,
    input wire logic i_act_jtag,
    input wire logic i_act_two_wire,
    input wire logic i_two_wire_dormant_req,
    output dps_pkg::dps_mode_t o_mode,
    output dps_pkg::dps_tap_t o_tap_state,
    output logic o_dormant_state,
    output logic o_jtag_selected_in_reset,
    output logic o_two_wire_selected_in_reset
);
    import dps_pkg::*;

    typedef struct packed {
        logic ck_a;
        logic ck_b;
        logic ck_c;
        logic ck_stable;
        logic dm_a;
        logic dm_b;
        logic dm_c;
        logic dm_stable;
        logic tr_a;
        logic tr_b;
        logic tr_c;
        logic tr_stable;
        dps_tap_t tap;
        dps_mode_t mode;
        logic [5:0] run;
        logic [4:0] bc;
        logic [15:0] shift;
        logic armed;
        logic alert_armed;
        logic jsr;
        logic swr;
        logic dorm;
    } dps_st_t;

    localparam dps_mode_t MODE_RST = JTAG_PRESENT ? MODE_JTAG : MODE_DORMANT;
    localparam dps_st_t ST_RST = '{ck_a: 1'b0, ck_b: 1'b0, ck_c: 1'b0, ck_stable: 1'b0,
        dm_a: 1'b1, dm_b: 1'b1, dm_c: 1'b1, dm_stable: 1'b1,
        tr_a: 1'b1, tr_b: 1'b1, tr_c: 1'b1, tr_stable: 1'b1,
        tap: TAP_TLR, mode: MODE_RST, run: 6'h00, bc: PAT_DONE, shift: 16'hFFFF,
        armed: 1'b1, alert_armed: 1'b0, jsr: JTAG_PRESENT, swr: 1'b0, dorm: !JTAG_PRESENT};

    logic rst_a;
    logic rst_n;
    dps_st_t st;
    dps_st_t next_st;
    dps_zs_if zi();

    function automatic dps_tap_t tap_step(input dps_tap_t s, input logic tms);
        dps_tap_t n;
        n = s;
        case (s)
            TAP_TLR: n = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: n = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR: n = tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: n = tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR: n = tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_RTI;
            default: n = TAP_TLR;
        endcase
        return n;
    endfunction

    // Reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    logic ck_rise;
    logic tms;
    logic trst;
    logic in_reset;
    logic match;
    logic [15:0] shifted;
    logic [5:0] run_nx;
    dps_tap_t tap_nx;

    always_comb begin
        next_st = st;
        next_st.ck_a = i_debug_clock_pin;
        next_st.ck_b = st.ck_a;
        next_st.ck_c = st.ck_b;
        next_st.dm_a = i_data_mode_pin;
        next_st.dm_b = st.dm_a;
        next_st.dm_c = st.dm_b;
        next_st.tr_a = i_tap_reset_n;
        next_st.tr_b = st.tr_a;
        next_st.tr_c = st.tr_b;
        if (st.ck_b == st.ck_c) begin
            next_st.ck_stable = st.ck_c;
        end
        if (st.dm_b == st.dm_c) begin
            next_st.dm_stable = st.dm_c;
        end
        if (st.tr_b == st.tr_c) begin
            next_st.tr_stable = st.tr_c;
        end
        ck_rise = st.ck_b == st.ck_c && st.ck_c && !st.ck_stable;
        tms = (st.dm_b == st.dm_c) ? st.dm_c : st.dm_stable;
        trst = st.tr_b == st.tr_c && !st.tr_c;
        tap_nx = tap_step(st.tap, tms);
        shifted = {st.shift[14:0], tms};
        run_nx = (st.run < LINE_RESET_HIGHS) ? st.run + 6'h01 : st.run;
        // Reset condition counts the high bit being taken, so the minimum run suffices
        in_reset = (st.mode == MODE_TWO_WIRE && run_nx >= LINE_RESET_HIGHS) ||
                   (st.mode == MODE_JTAG && run_nx >= TAP_RESET_HIGHS && tap_nx == TAP_TLR);
        match = 1'b0;

        // one step per rising debug clock edge in JTAG mode, and one each cycle the TAP reset pin is low
        zi.step = (ck_rise && st.mode == MODE_JTAG) || trst;
        zi.tap_next = trst ? TAP_TLR : tap_nx;
        if (zi.step) begin
            next_st.tap = zi.tap_next;
        end

        if (ck_rise && st.mode != MODE_DORMANT) begin
            next_st.shift = shifted;
            next_st.run = !tms ? 6'h00 : run_nx;
            // bit count restarts only from reset
            if (tms && in_reset) begin
                next_st.bc = 5'h00;
            end else if (st.bc < PAT_DONE) begin
                next_st.bc = st.bc + 5'h01;
            end
            if (tms && in_reset) begin
                next_st.armed = 1'b1;
            end
            if (st.armed && st.bc == PAT_LAST) begin
                if (st.mode == MODE_TWO_WIRE && shifted == SEL_TO_JTAG) begin
                    match = 1'b1;
                    next_st.mode = MODE_JTAG;
                end
                if (st.mode == MODE_JTAG && shifted == SEL_TO_TWO_WIRE) begin
                    match = 1'b1;
                    next_st.mode = MODE_TWO_WIRE;
                    next_st.run = 6'h00;
                end
            end
            if (match) begin
                next_st.armed = 1'b0;
            end
        end

        // locked six at idle enters dormant
        if (st.mode == MODE_JTAG && zi.enter) begin
            next_st.mode = MODE_DORMANT;
            next_st.alert_armed = 1'b0;
        end
        // two-wire side may also go dormant
        if (st.mode == MODE_TWO_WIRE && i_two_wire_dormant_req) begin
            next_st.mode = MODE_DORMANT;
            next_st.alert_armed = 1'b0;
        end

        if (st.mode == MODE_DORMANT) begin
            if (i_alert_seen) begin
                next_st.alert_armed = 1'b1;
            end else if (st.alert_armed && i_act_jtag && JTAG_PRESENT) begin
                // TAP resumes the state it left
                next_st.mode = MODE_JTAG;
                next_st.alert_armed = 1'b0;
                next_st.run = 6'h00;
                next_st.bc = PAT_DONE;
            end else if (st.alert_armed && i_act_two_wire) begin
                next_st.mode = MODE_TWO_WIRE;
                next_st.alert_armed = 1'b0;
                next_st.run = 6'h00;
                next_st.bc = PAT_DONE;
            end
        end

        next_st.jsr = next_st.mode == MODE_JTAG && next_st.tap == TAP_TLR;
        next_st.swr = next_st.mode == MODE_TWO_WIRE && next_st.run >= LINE_RESET_HIGHS;
        next_st.dorm = next_st.mode == MODE_DORMANT;
    end

    dps_zscan u_zscan (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .zi(zi)
    );

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_RST;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_mode = st.mode;
    assign o_tap_state = st.tap;
    assign o_dormant_state = st.dorm;
    assign o_jtag_selected_in_reset = st.jsr;
    assign o_two_wire_selected_in_reset = st.swr;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    chk_dormant_held_quiet: assert property (st.mode == MODE_DORMANT && !st.alert_armed &&
        !i_alert_seen |=> st.mode == MODE_DORMANT) else $error("dormant left without alert");
    chk_exit_after_alert: assert property (st.mode == MODE_DORMANT ##1
        st.mode != MODE_DORMANT |-> $past(st.alert_armed)) else $error("exit without alert");
    chk_to_jtag_pattern: assert property (st.mode == MODE_TWO_WIRE ##1
        st.mode == MODE_JTAG && !$past(st.alert_armed) |-> st.shift == SEL_TO_JTAG && !st.armed)
        else $error("switch to JTAG without pattern");
    chk_to_two_wire_pat: assert property (st.mode == MODE_JTAG ##1
        st.mode == MODE_TWO_WIRE |-> st.shift == SEL_TO_TWO_WIRE && !st.armed)
        else $error("switch to two-wire without pattern");
    chk_tlr_after_highs: assert property (st.mode == MODE_JTAG &&
        st.run >= TAP_RESET_HIGHS |-> st.tap == TAP_TLR) else $error("TAP not reset by highs");
    chk_dormant_from_idle: assert property (st.mode == MODE_JTAG ##1
        st.mode == MODE_DORMANT |-> st.tap == TAP_RTI && $past(zi.count) == ZS_DORMANT)
        else $error("dormant entry not at idle with six");
    chk_two_wire_pending: assert property (st.mode == MODE_DORMANT ##1
        st.mode == MODE_TWO_WIRE |-> !o_two_wire_selected_in_reset)
        else $error("two-wire activation not reset-pending");
    chk_dormant_tap_kept: assert property (st.mode == MODE_DORMANT && !trst
        |=> $stable(st.tap)) else $error("TAP moved while dormant");

    cov_jtag_to_two_wire: cover property (st.mode == MODE_JTAG ##1 st.mode == MODE_TWO_WIRE);
    cov_two_wire_to_jtag: cover property (st.mode == MODE_TWO_WIRE ##1 st.mode == MODE_JTAG);
    cov_enter_dormant: cover property (st.mode == MODE_JTAG ##1 st.mode == MODE_DORMANT);
    cov_wake_jtag: cover property (st.mode == MODE_DORMANT ##1 st.mode == MODE_JTAG);

endmodule // dps_top
`default_nettype wire

// [dps_probe.sv]
// Purpose: Behavioural debug probe driving the debug clock and data/mode pins
// Assumes: i_mclk at 125 MHz; one debug bit spans ten i_mclk cycles (80 ns)
// Notes: Debug clock stands low between frames; pins change only on i_mclk rises
`timescale 1ns/1ps
`default_nettype none
module dps_probe (
    input wire logic i_mclk,
    output logic o_debug_clock_pin,
    output logic o_data_mode_pin
);
    initial begin
        o_debug_clock_pin = 1'b0;
        o_data_mode_pin = 1'b1;
    end

    // Data changes with the fall and holds through the high half for the sampler
    task automatic send_bits(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_mclk);
            o_debug_clock_pin <= 1'b0;
            o_data_mode_pin <= v[i];
            repeat (4) @(posedge i_mclk);
            o_debug_clock_pin <= 1'b1;
            repeat (5) @(posedge i_mclk);
        end
        @(posedge i_mclk);
        o_debug_clock_pin <= 1'b0;
    endtask

    task automatic highs(input int n);
        repeat (n) send_bits(64'h1, 1);
    endtask

    task automatic pattern(input logic [15:0] p);
        send_bits({48'h0, p}, 16);
    endtask

    // reset first, so the zero scan counter starts from zero
    task automatic to_dormant();
        highs(5);
        send_bits({33'h0, 31'h2EEEEEE6}, 31);
    endtask

    task automatic settle_idle();
        send_bits(64'h0, 1);
    endtask
endmodule // dps_probe
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the protocol selection watcher
// Assumes: Probe model drives the link; alert and activation matches are pulses
// Notes: Second instance is the two-wire only build, checked alongside the first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dps_pkg::*;
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    dps_tap_t tap2;
    logic dorm2;
    logic jsel2;
    logic wsel2;
    logic i_tap_reset_n = 1'b1;
    logic i_alert_seen = 1'b0;
    logic i_act_jtag = 1'b0;
    logic i_act_two_wire = 1'b0;
    logic i_two_wire_dormant_req = 1'b0;
    wire logic tck;
    wire logic tms;
    dps_mode_t o_mode;
    dps_mode_t mode2;
    dps_tap_t o_tap_state;
    logic o_dormant_state;
    logic jsel;
    logic wsel;
    int err_total;
    int total_checks;

    always #4 i_mclk = ~i_mclk;

    dps_probe p (.i_mclk(i_mclk), .o_debug_clock_pin(tck), .o_data_mode_pin(tms));

    dps_top uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_debug_clock_pin(tck),
        .i_data_mode_pin(tms), .i_tap_reset_n(i_tap_reset_n), .i_alert_seen(i_alert_seen),
        .i_act_jtag(i_act_jtag), .i_act_two_wire(i_act_two_wire),
        .i_two_wire_dormant_req(i_two_wire_dormant_req), .o_mode(o_mode),
        .o_tap_state(o_tap_state), .o_dormant_state(o_dormant_state),
        .o_jtag_selected_in_reset(jsel), .o_two_wire_selected_in_reset(wsel));

    dps_top #(.JTAG_PRESENT(1'b0)) uut2 (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_debug_clock_pin(tck), .i_data_mode_pin(tms), .i_tap_reset_n(i_tap_reset_n),
        .i_alert_seen(i_alert_seen), .i_act_jtag(i_act_jtag), .i_act_two_wire(i_act_two_wire),
        .i_two_wire_dormant_req(i_two_wire_dormant_req), .o_mode(mode2), .o_tap_state(tap2),
        .o_dormant_state(dorm2), .o_jtag_selected_in_reset(jsel2),
        .o_two_wire_selected_in_reset(wsel2));

    task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Sample on the falling edge so every register update has landed
    task automatic settle();
        repeat (3) @(negedge i_mclk);
    endtask

    task automatic act(input logic alert, input logic jt);
        @(posedge i_mclk);
        i_alert_seen <= alert;
        @(posedge i_mclk);
        i_alert_seen <= 1'b0;
        i_act_jtag <= jt;
        i_act_two_wire <= ~jt;
        @(posedge i_mclk);
        i_act_jtag <= 1'b0;
        i_act_two_wire <= 1'b0;
        settle();
    endtask

    // TAP walk: reset, idle, optional scan with shift, n empty scans, optional IR detour
    task automatic zbs_seq(input logic shift_first, input int n, input int after_ir);
        p.highs(5);
        p.send_bits(64'h0, 1);
        if (shift_first) begin
            p.send_bits(64'h13, 5);
        end
        repeat (n) p.send_bits(64'hB, 4);
        if (after_ir > 0) begin
            p.send_bits(64'h1B, 5);
            repeat (after_ir) p.send_bits(64'hB, 4);
        end
        p.send_bits(64'h26, 6);
        settle();
    endtask

    task automatic t_reset();
        chk("mode", o_mode, MODE_JTAG);
        chk("tap", o_tap_state, TAP_TLR);
        chk("jtag_in_reset", jsel, 1'b1);
        chk("dormant", o_dormant_state, 1'b0);
        chk("two_wire_only_mode", mode2, MODE_DORMANT);
        chk("two_wire_only_dormant", dorm2, 1'b1);
        chk("two_wire_only_tap", tap2, TAP_TLR);
        chk("two_wire_only_jtag_rst", jsel2, 1'b0);
        chk("two_wire_only_line_rst", wsel2, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_to_two_wire();
        p.highs(5);
        p.pattern(SEL_TO_TWO_WIRE);
        p.highs(50);
        settle();
        chk("mode", o_mode, MODE_TWO_WIRE);
        chk("two_wire_in_reset", wsel, 1'b1);
        $display("test jtag to two-wire done");
    endtask

    task automatic t_select_jtag();
        p.send_bits({47'h0, 1'b0, SEL_TO_JTAG}, 17);
        p.highs(5);
        settle();
        chk("mode_extra_low", o_mode, MODE_TWO_WIRE);
        chk("two_wire_in_reset", wsel, 1'b0);
        p.highs(50);
        p.pattern(SEL_TO_JTAG);
        settle();
        chk("mode", o_mode, MODE_JTAG);
        p.highs(5);
        settle();
        chk("tap", o_tap_state, TAP_TLR);
        chk("jtag_in_reset", jsel, 1'b1);
        $display("test two-wire to jtag done");
    endtask

    task automatic t_jtag_dormant();
        p.to_dormant();
        settle();
        chk("mode", o_mode, MODE_DORMANT);
        chk("tap", o_tap_state, TAP_RTI);
        chk("dormant", o_dormant_state, 1'b1);
        act(1'b0, 1'b1);
        chk("mode_no_alert", o_mode, MODE_DORMANT);
        p.highs(5);
        p.pattern(SEL_TO_TWO_WIRE);
        p.highs(50);
        settle();
        chk("mode_pins", o_mode, MODE_DORMANT);
        chk("tap_frozen", o_tap_state, TAP_RTI);
        act(1'b1, 1'b1);
        chk("mode", o_mode, MODE_JTAG);
        chk("two_wire_only_no_jtag", mode2, MODE_DORMANT);
        chk("dormant", o_dormant_state, 1'b0);
        chk("tap", o_tap_state, TAP_RTI);
        p.settle_idle();
        settle();
        chk("tap_idle", o_tap_state, TAP_RTI);
        chk("mode_idle", o_mode, MODE_JTAG);
        $display("test jtag to dormant done");
    endtask

    task automatic t_zero_scans();
        zbs_seq(1'b0, 5, 0);
        chk("mode_count5", o_mode, MODE_JTAG);
        chk("tap_count5", o_tap_state, TAP_RTI);
        zbs_seq(1'b0, 14, 0);
        chk("mode_count14", o_mode, MODE_JTAG);
        zbs_seq(1'b0, 3, 6);
        chk("mode_ir_clear", o_mode, MODE_DORMANT);
        act(1'b1, 1'b1);
        zbs_seq(1'b1, 6, 0);
        chk("mode_shift_scan", o_mode, MODE_DORMANT);
        act(1'b1, 1'b0);
        chk("mode", o_mode, MODE_TWO_WIRE);
        chk("two_wire_in_reset", wsel, 1'b0);
        chk("two_wire_only_wake", mode2, MODE_TWO_WIRE);
        p.highs(50);
        settle();
        chk("two_wire_line_reset", wsel, 1'b1);
        chk("two_wire_only_line_reset", wsel2, 1'b1);
        $display("test zero scans done");
    endtask

    task automatic t_two_wire_dormant();
        @(posedge i_mclk);
        i_two_wire_dormant_req <= 1'b1;
        @(posedge i_mclk);
        i_two_wire_dormant_req <= 1'b0;
        settle();
        chk("mode", o_mode, MODE_DORMANT);
        chk("two_wire_only_req", mode2, MODE_DORMANT);
        act(1'b1, 1'b1);
        chk("mode_out", o_mode, MODE_JTAG);
        chk("two_wire_only_stays", dorm2, 1'b1);
        chk("tap", o_tap_state, TAP_RTI);
        $display("test two-wire to dormant done");
    endtask

    task automatic t_abandon();
        @(posedge i_mclk);
        i_tap_reset_n <= 1'b0;
        repeat (10) @(posedge i_mclk);
        i_tap_reset_n <= 1'b1;
        settle();
        chk("tap_pin_reset", o_tap_state, TAP_TLR);
        p.send_bits(64'h0, 1);
        repeat (3) p.send_bits(64'hB, 4);
        p.highs(5);
        p.pattern(SEL_TO_TWO_WIRE);
        p.highs(50);
        settle();
        chk("mode", o_mode, MODE_TWO_WIRE);
        $display("test abandon done");
    endtask

    // Clock enable low must freeze the TAP although highs would reset it
    task automatic t_freeze();
        @(posedge i_mclk);
        i_ce <= 1'b0;
        p.highs(5);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        settle();
        chk("tap_frozen_ce", o_tap_state, TAP_RTI);
        chk("mode_frozen_ce", o_mode, MODE_JTAG);
        $display("test clock enable freeze done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        err_total = 0;
        total_checks = 0;
        repeat (16) @(posedge i_mclk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_mclk);
        settle();
        t_reset();
        t_to_two_wire();
        t_select_jtag();
        t_jtag_dormant();
        t_zero_scans();
        t_two_wire_dormant();
        t_freeze();
        t_abandon();
        end_sim();
    end

    // Whole run needs about 6.5k cycles; allow well over that
    initial begin
        #400000;
        err_total++;
        $display("ERROR watchdog expected done seen timeout");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
